// File: shared/pcg_pkg.sv
// Package of register offsets, field positions and reset values for the peripheral clock gate.
package pcg_pkg;

  // Register byte offsets inside the peripheral's address space.
  localparam logic [7:0] PCG_OFF_ENABLE_SET   = 8'h50;
  localparam logic [7:0] PCG_OFF_ENABLE_CLEAR = 8'h54;
  localparam logic [7:0] PCG_OFF_STATUS       = 8'h58;

  // Field positions shared by all three registers.
  localparam int PCG_BIT_PIO  = 0;
  localparam int PCG_BIT_MAIN = 1;

  // Address, data and field widths.
  localparam int PCG_ADDR_W  = 8;
  localparam int PCG_DATA_W  = 32;
  localparam int PCG_CLOCK_N = 2;

  // Both section clocks run after reset.
  localparam logic [1:0] PCG_RESET_RUN = 2'h3;

  // Bus access decode result.
  typedef enum logic [1:0] {
    PCG_REG_NONE,
    PCG_REG_SET,
    PCG_REG_CLEAR,
    PCG_REG_STATUS
  } pcg_reg_t;

  // Decode a byte address into a register selector; unmapped gives none.
  function automatic pcg_reg_t pcg_decode(input logic [PCG_ADDR_W-1:0] addr);
    pcg_reg_t sel;
    sel = PCG_REG_NONE;
    if (addr == PCG_OFF_ENABLE_SET) begin
      sel = PCG_REG_SET;
    end else if (addr == PCG_OFF_ENABLE_CLEAR) begin
      sel = PCG_REG_CLEAR;
    end else if (addr == PCG_OFF_STATUS) begin
      sel = PCG_REG_STATUS;
    end
    return sel;
  endfunction : pcg_decode

endpackage : pcg_pkg

// File: hw/pcg_gate_cell.sv
// Glitch-free clock gate cell with a latch-free enable flop on the falling edge.
module pcg_gate_cell (
  input  wire logic clk_i,
  input  wire logic enable_i,
  output logic      gclk_o
);

  logic enable_low;

  // The enable is retimed on the falling edge so the gated clock never shows a runt pulse.
  always_ff @(negedge clk_i) begin
    enable_low <= enable_i;
  end

  // Gated clock: high only while the retimed enable stands.
  assign gclk_o = clk_i & enable_low;

endmodule : pcg_gate_cell

// File: hw/pcg_apb_decode.sv
// APB access qualifier and register decode for the clock gate.
module pcg_apb_decode
  import pcg_pkg::*;
(
  input  wire logic                      psel_i,
  input  wire logic                      penable_i,
  input  wire logic                      pwrite_i,
  input  wire logic [pcg_pkg::PCG_ADDR_W-1:0] paddr_i,
  output logic                           wr_set_o,
  output logic                           wr_clear_o,
  output logic                           rd_status_o,
  output logic                           unmapped_o
);

  pcg_reg_t sel;
  logic     access;

  // Access phase of a transfer; the slave always answers in it.
  assign access      = psel_i & penable_i;
  assign sel         = pcg_decode(paddr_i);
  assign wr_set_o    = access & pwrite_i & (sel == PCG_REG_SET);
  assign wr_clear_o  = access & pwrite_i & (sel == PCG_REG_CLEAR);
  assign rd_status_o = access & ~pwrite_i & (sel == PCG_REG_STATUS);
  assign unmapped_o  = access & (sel == PCG_REG_NONE);

endmodule : pcg_apb_decode

// File: hw/pcg_top.sv
// Peripheral clock gate: APB set, clear and status registers steering two section clocks.
// Overview of operation
// - A one-bit write to the enable-set register at 0x50 switches on the selected section clocks.
// - A write to the enable-clear register at 0x54 switches off the selected section clocks.
// - The status register at 0x58 reads which section clocks are currently running.
// - Bit 0 stands for the parallel I/O section clock and bit 1 for the main-function clock.
// - A disable stops the clock at once, without waiting for the section to finish its work.
// - A stopped section keeps its state and resumes from it once its clock returns.
// - The shared interrupt logic keeps its clock while either section clock runs.
// - This gating is independent of the global power controller and never touches its settings.
//
// The APB interface to the registers was left to the implementer.
module pcg_top
  import pcg_pkg::*;
(
  input  wire logic                           clk_i,
  input  wire logic                           reset_i,
  input  wire logic                           clk_en_i,
  input  wire logic                           psel_i,
  input  wire logic                           penable_i,
  input  wire logic                           pwrite_i,
  input  wire logic [pcg_pkg::PCG_ADDR_W-1:0] paddr_i,
  input  wire logic [pcg_pkg::PCG_DATA_W-1:0] pwdata_i,
  output logic      [pcg_pkg::PCG_DATA_W-1:0] prdata_o,
  output logic                                pready_o,
  output logic                                pslverr_o,
  output logic                                pio_run_o,
  output logic                                main_run_o,
  output logic                                irq_run_o,
  output logic                                pio_gclk_o,
  output logic                                main_gclk_o,
  output logic                                irq_gclk_o
);

  logic       wr_set;
  logic       wr_clear;
  logic       rd_status;
  logic       unmapped;
  logic [1:0] run;
  logic [1:0] next_run;
  logic       first_phase;

  // Bus decode lives in its own small module so the register file stays readable.
  pcg_apb_decode u_decode (
    .psel_i      (psel_i),
    .penable_i   (penable_i),
    .pwrite_i    (pwrite_i),
    .paddr_i     (paddr_i),
    .wr_set_o    (wr_set),
    .wr_clear_o  (wr_clear),
    .rd_status_o (rd_status),
    .unmapped_o  (unmapped)
  );

  // The slave answers on the second access cycle, so pready is a flop and not a tie.
  assign first_phase = psel_i & penable_i & ~pready_o;

  // Next run state: set bits turn clocks on, clear bits off; a zero changes nothing.
  always_comb begin
    next_run = run;
    if (wr_set && first_phase) begin
      next_run = next_run | pwdata_i[PCG_CLOCK_N-1:0];
    end
    if (wr_clear && first_phase) begin
      next_run = next_run & ~pwdata_i[PCG_CLOCK_N-1:0];
    end
  end

  // Run register; the global power controller has no path into it.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      run <= PCG_RESET_RUN;
    end else if (clk_en_i) begin
      run <= next_run;
    end
  end

  // Ready pulses for one cycle after the first access cycle.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else if (clk_en_i) begin
      pready_o  <= first_phase;
      pslverr_o <= first_phase & unmapped;
    end
  end

  // Read data: status in the low two bits, the rest zero; write-only offsets read zero.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      prdata_o <= '0;
    end else if (clk_en_i) begin
      prdata_o <= '0;
      if (rd_status && first_phase) begin
        prdata_o[PCG_BIT_PIO]  <= run[PCG_BIT_PIO];
        prdata_o[PCG_BIT_MAIN] <= run[PCG_BIT_MAIN];
      end
    end
  end

  // Registered run levels for the sections and the shared interrupt logic.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pio_run_o  <= PCG_RESET_RUN[PCG_BIT_PIO];
      main_run_o <= PCG_RESET_RUN[PCG_BIT_MAIN];
      irq_run_o  <= 1'b1;
    end else if (clk_en_i) begin
      pio_run_o  <= next_run[PCG_BIT_PIO];
      main_run_o <= next_run[PCG_BIT_MAIN];
      irq_run_o  <= next_run[PCG_BIT_PIO] | next_run[PCG_BIT_MAIN];
    end
  end

  // Gated clocks: a section with its clock stopped sees no edges and so holds its state.
  pcg_gate_cell u_gate_pio (
    .clk_i    (clk_i),
    .enable_i (pio_run_o),
    .gclk_o   (pio_gclk_o)
  );

  pcg_gate_cell u_gate_main (
    .clk_i    (clk_i),
    .enable_i (main_run_o),
    .gclk_o   (main_gclk_o)
  );

  pcg_gate_cell u_gate_irq (
    .clk_i    (clk_i),
    .enable_i (irq_run_o),
    .gclk_o   (irq_gclk_o)
  );

endmodule : pcg_top

// File: bench/pcg_top_properties.sv
// Port-level checks for the peripheral clock gate.
module pcg_top_properties
  import pcg_pkg::*;
(
  input wire logic                           clk_i,
  input wire logic                           reset_i,
  input wire logic                           clk_en_i,
  input wire logic                           psel_i,
  input wire logic                           penable_i,
  input wire logic                           pwrite_i,
  input wire logic [pcg_pkg::PCG_ADDR_W-1:0] paddr_i,
  input wire logic [pcg_pkg::PCG_DATA_W-1:0] pwdata_i,
  input wire logic [pcg_pkg::PCG_DATA_W-1:0] prdata_o,
  input wire logic                           pready_o,
  input wire logic                           pio_run_o,
  input wire logic                           main_run_o,
  input wire logic                           irq_run_o
);
  // All checks share the bus clock and sleep while reset is held.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // An access is taken on its first access cycle; the writes are built on that.
  sequence seq_take; psel_i && penable_i && !pready_o && clk_en_i; endsequence
  sequence seq_wr_set; seq_take ##0 (pwrite_i && paddr_i == PCG_OFF_ENABLE_SET); endsequence
  sequence seq_wr_clr; seq_take ##0 (pwrite_i && paddr_i == PCG_OFF_ENABLE_CLEAR); endsequence
  chk_answer_next: assert property (seq_take |=> pready_o)
    else $error("Access not answered in the next cycle.");
  chk_set_pio: assert property (seq_wr_set ##0 pwdata_i[PCG_BIT_PIO] |=> pio_run_o)
    else $error("Set did not start the parallel I/O clock.");
  chk_set_main: assert property (seq_wr_set ##0 pwdata_i[PCG_BIT_MAIN] |=> main_run_o)
    else $error("Set did not start the main clock.");
  chk_clear_main: assert property (seq_wr_clr ##0 pwdata_i[PCG_BIT_MAIN] |=> !main_run_o)
    else $error("Clear did not stop the main clock at once.");
  chk_zero_keeps: assert property ((seq_wr_set or seq_wr_clr) ##0 !pwdata_i[PCG_BIT_PIO] |=> $stable(pio_run_o))
    else $error("A zero bit changed the parallel I/O clock.");
  chk_hold_idle: assert property (!(psel_i && penable_i && pwrite_i) |=> $stable({main_run_o, pio_run_o}))
    else $error("Run state moved without a write.");
  chk_status_read: assert property (seq_take ##0 (!pwrite_i && paddr_i == PCG_OFF_STATUS)
    |=> prdata_o == {30'h0000_0000, $past(main_run_o), $past(pio_run_o)}) else $error("Status read is wrong.");
  chk_irq_either: assert property (irq_run_o == (pio_run_o || main_run_o))
    else $error("Shared interrupt clock does not follow the sections.");
endmodule : pcg_top_properties

bind pcg_top pcg_top_properties u_props (.*);

// File: bench/tb_top.sv
// Self-checking bench for the peripheral clock gate.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import pcg_pkg::*;
  `define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; $display("FAIL %0t %h %h", $time, g, e); end end
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [1:0] e;} pcg_row_t;
  logic        clk_i, reset_i, clk_en_i, psel_i, penable_i, pwrite_i, err;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic        pready_o, pslverr_o, pio_run_o, main_run_o, irq_run_o, pio_gclk_o, main_gclk_o, irq_gclk_o;
  int          miscompares = 0;
  int          num_checks = 0;
  // Writes to set, clear and status, with the run state each should leave.
  pcg_row_t rows [8] = '{'{8'h54, 32'h0000_0001, 2'h2}, '{8'h54, 32'h0000_0002, 2'h0},
    '{8'h50, 32'h0000_0002, 2'h2}, '{8'h50, 32'h0000_0000, 2'h2}, '{8'h58, 32'h0000_0003, 2'h2},
    '{8'h50, 32'hFFFF_FFFD, 2'h3}, '{8'h54, 32'hFFFF_FFFC, 2'h3}, '{8'h54, 32'h0000_0003, 2'h0}};
  pcg_top dut (.*);
  // Free-running 40 MHz clock.
  initial begin
    clk_i = 1'h0;
    forever #12.5 clk_i = ~clk_i;
  end
  // Prints the counts and the verdict, then stops the run.
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out
  // One APB transfer; the wait is bounded so a dead slave cannot hang the run.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk_i);
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {1'h1, 1'h0, w, a, d};
    @(posedge clk_i);
    penable_i <= 1'h1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'h1 && n < 20);
    r = prdata_o;
    e = pslverr_o;
    {psel_i, penable_i} <= 2'h0;
    if (n >= 20) begin
      miscompares++;
      close_out();
    end
  endtask : apb
  // Reset first, then the table, then the odd cases. Clock enable drops once, near the end.
  initial begin
    {reset_i, clk_en_i, psel_i, penable_i, pwrite_i} = 5'h18;
    paddr_i = 8'h00;
    pwdata_i = 32'h0000_0000;
    repeat (10) @(posedge clk_i);
    reset_i <= 1'h0;
    @(posedge clk_i);
    `CHK({main_run_o, pio_run_o, pready_o, prdata_o}, 35'h6_0000_0000)
    foreach (rows[i]) begin
      apb(1'h1, rows[i].a, rows[i].d, rd, err);
      `CHK({main_run_o, pio_run_o}, rows[i].e)
      `CHK(irq_run_o, |rows[i].e)
      apb(1'h0, PCG_OFF_STATUS, 32'h0000_0000, rd, err);
      `CHK({err, rd}, {31'h0000_0000, rows[i].e})
    end
    apb(1'h0, 8'h50, 32'h0000_0000, rd, err);
    `CHK({err, rd}, 33'h0_0000_0000)
    apb(1'h0, 8'h5C, 32'h0000_0000, rd, err);
    `CHK({err, rd}, 33'h1_0000_0000)
    // A reset in mid-run, with both clocks stopped, brings both back.
    @(posedge clk_i);
    reset_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'h0;
    @(posedge clk_i);
    `CHK({main_run_o, pio_run_o, irq_run_o}, 3'h7)
    // A clear held while clock enable is low must wait, then land once the enable returns.
    @(posedge clk_i);
    {clk_en_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {4'h5, PCG_OFF_ENABLE_CLEAR, 32'h0000_0003};
    @(posedge clk_i);
    penable_i <= 1'h1;
    repeat (3) @(posedge clk_i);
    `CHK({pready_o, main_run_o, pio_run_o}, 3'h3)
    clk_en_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    `CHK({pready_o, main_run_o, pio_run_o}, 3'h4)
    {psel_i, penable_i} <= 2'h0;
    // Gated clocks are looked at in the high phase, where a running one shows the clock level.
    #5;
    `CHK({irq_gclk_o, main_gclk_o, pio_gclk_o}, 3'h0)
    apb(1'h1, PCG_OFF_ENABLE_SET, 32'h0000_0001, rd, err);
    #5;
    `CHK({irq_gclk_o, main_gclk_o, pio_gclk_o}, 3'h5)
    close_out();
  end
endmodule : tb_top
